// *** tb/fdd_link_assertions.sv ***
// concurrent checks on the controller-to-drive input lines
// assumes both ends share clk and the synchronous reset sys_rst
`include "fdd_cfg.svh"
`default_nettype none
module fdd_link_checker #(
  parameter int ERASE_CYC = `ERASE_CYC
) (
  // system
  input wire logic       clk,
  input wire logic       sys_rst,
  // input lines
  input wire logic [3:0] unit_sel_n,
  input wire logic       direction_n,
  input wire logic       step_n,
  input wire logic       write_data_n,
  input wire logic       write_gate_n,
  input wire logic       side_sel_n,
  input wire logic       inner_track_n,
  input wire logic       head_engage_n,
  input wire logic       activity_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int erase_cnt;
  int side_cnt;
  int pos;
  // one cycle of slack on each wait, so the host may act on the last cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      erase_cnt <= 0;
      side_cnt  <= 0;
      pos       <= 0;
    end else begin
      erase_cnt <= $rose(write_gate_n) ? ERASE_CYC - 1 : (erase_cnt > 0 ? erase_cnt - 1 : 0);
      side_cnt  <= !$stable(side_sel_n) ? `SIDE_SETTLE_CYC - 1 : (side_cnt > 0 ? side_cnt - 1 : 0);
      if ($fell(step_n)) begin
        pos <= direction_n ? (pos > 0 ? pos - 1 : 0) : (pos < `LAST_TRACK ? pos + 1 : pos);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_idle;
    $fell(sys_rst) |-> (&unit_sel_n) && step_n && write_gate_n && write_data_n;
  endproperty
  a_idle: assert property (p_idle) else $error("lines not idle after reset");
  property p_one_sel;
    $countones(~unit_sel_n) <= 1;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("two selects low");
  property p_dir_setup;
    $rose(step_n) |-> $stable(direction_n) && direction_n == $past(direction_n, 10);
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("direction moved near step");
  property p_step_width;
    $fell(step_n) |-> !step_n [*8] ##1 !step_n ##1 !step_n ##1 step_n;
  endproperty
  a_step_width: assert property (p_step_width) else $error("step width wrong");
  property p_step_sel;
    $fell(step_n) |-> !(&unit_sel_n);
  endproperty
  a_step_sel: assert property (p_step_sel) else $error("step with no unit");
  property p_no_step_write;
    !write_gate_n |-> step_n;
  endproperty
  a_no_step_write: assert property (p_no_step_write) else $error("step while writing");
  property p_flux;
    $fell(write_data_n) |-> !write_gate_n ##1 write_data_n;
  endproperty
  a_flux: assert property (p_flux) else $error("flux outside write");
  property p_erase;
    erase_cnt != 0 |-> $stable(unit_sel_n) && $stable(side_sel_n);
  endproperty
  a_erase: assert property (p_erase) else $error("erase wait cut short");
  property p_side_settle;
    side_cnt != 0 |-> write_gate_n;
  endproperty
  a_side_settle: assert property (p_side_settle) else $error("write before side settle");
  property p_low_cur;
    !write_gate_n && !$past(write_gate_n) |-> inner_track_n == (pos < `LOW_CUR_TRACK);
  endproperty
  a_low_cur: assert property (p_low_cur) else $error("inner line wrong in write");
endmodule
`default_nettype wire

// *** tb/tb_flexible_disk_drive_input_control.sv ***
// bench joining the controller end and the drive end over the line interface
// assumes a single-sided disk present and the drive jumpered as unit one
`default_nettype none
module tb_flexible_disk_drive_input_control
  import fdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, sys_rst, cmd_valid, cmd_ready, activity, busy, index_pulse;
  logic [1:0] unit;
  cmd_t       cmd;
  logic       selected, step_pulse, step_inward, write_enable, read_enable;
  logic       write_polarity, write_current_low, read_filter, head_side_one;
  logic       head_loaded, ready, activity_led, pol_q, saw_we, saw_low, refused;
  logic [6:0] track;
  int         mismatches, compares, pulses, flips;
  fdd_if lines_if ();
  fdd_host #(.ERASE_CYC(20)) u_fdd_host (.clk(clk), .sys_rst(sys_rst), .unit(unit),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .activity(activity),
    .busy(busy), .lines(lines_if.host));
  fdd_drive u_fdd_drive (.clk(clk), .sys_rst(sys_rst), .address_jumper(4'h2),
    .index_pulse(index_pulse), .disk_present(1'b1), .two_sided_media(1'b0),
    .lines(lines_if.drive), .selected(selected), .track(track), .step_pulse(step_pulse),
    .step_inward(step_inward), .write_enable(write_enable), .read_enable(read_enable),
    .write_polarity(write_polarity), .write_current_low(write_current_low),
    .read_filter(read_filter), .head_side_one(head_side_one), .head_loaded(head_loaded),
    .ready(ready), .activity_led(activity_led));
  fdd_link_checker #(.ERASE_CYC(20)) u_fdd_link_checker (.clk(clk), .sys_rst(sys_rst),
    .unit_sel_n(lines_if.unit_sel_n), .direction_n(lines_if.direction_n),
    .step_n(lines_if.step_n), .write_data_n(lines_if.write_data_n),
    .write_gate_n(lines_if.write_gate_n), .side_sel_n(lines_if.side_sel_n),
    .inner_track_n(lines_if.inner_track_n), .head_engage_n(lines_if.head_engage_n),
    .activity_n(lines_if.activity_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clk) begin
    if (step_pulse === 1'b1) pulses++;
    if (write_polarity !== pol_q) flips++;
    if (write_enable === 1'b1) begin
      saw_we = 1'b1;
      saw_low = write_current_low;
    end
    pol_q = write_polarity;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a bound that runs out is scored as a failed compare
  task automatic send(input logic [1:0] u, input cmd_kind_t k, input logic [7:0] a);
    int n;
    n = 0;
    @(negedge clk);
    unit = u;
    cmd = '{k, a};
    cmd_valid = 1'b1;
    if (cmd_ready !== 1'b1) refused = 1'b1;
    while (cmd_ready !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 30000) begin check(8'h00, 8'h01); final_report(); end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic idle(input string name);
    int n, q;
    n = 0;
    q = 0;
    while (q < 4 && n < 30000) begin
      @(negedge clk);
      n++;
      q = (busy === 1'b0 && cmd_ready === 1'b1) ? q + 1 : 0;
    end
    if (n >= 30000) begin check(8'h00, 8'h01); final_report(); end
    $display("test %s done", name);
  endtask
  task automatic idx(input int n);
    repeat (n) begin
      @(negedge clk);
      index_pulse = 1'b1;
      repeat (3) @(negedge clk);
      index_pulse = 1'b0;
      repeat (20) @(negedge clk);
    end
  endtask
  initial begin
    sys_rst = 1'b1; cmd_valid = 1'b0; unit = 2'h0; cmd = '0; activity = 1'b0;
    index_pulse = 1'b0; mismatches = 0; compares = 0; refused = 1'b0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    check(8'(track), 8'h00);
    idx(2);
    check(8'(ready), 8'h00);
    idx(1);
    idle("media");
    check(8'(ready), 8'h01);
    pulses = 0;
    send(2'h1, cmd_step_in, 8'h03);
    idle("step in");
    check(8'(track), 8'h03);
    check(8'(pulses), 8'h03);
    check(8'(step_inward), 8'h01);
    check(8'(selected), 8'h01);
    send(2'h1, cmd_step_out, 8'h01);
    idle("step out");
    check(8'(track), 8'h02);
    check(8'(step_inward), 8'h00);
    send(2'h1, cmd_step_in, 8'h2a);
    flips = 0;
    saw_we = 1'b0;
    send(2'h1, cmd_write, 8'h04);
    idle("write");
    check(8'(track), 8'h2c);
    check(8'(flips), 8'h04);
    check(8'(saw_we), 8'h01);
    check(8'(saw_low), 8'h01);
    check(8'({write_enable, read_enable}), 8'h01);
    send(2'h1, cmd_read, 8'h00);
    idle("read low");
    check(8'(read_filter), 8'h00);
    send(2'h1, cmd_step_in, 8'h10);
    send(2'h1, cmd_read, 8'h00);
    idle("read high");
    check(8'(track), 8'h3c);
    check(8'(read_filter), 8'h01);
    send(2'h1, cmd_side, 8'h01);
    send(2'h1, cmd_load, 8'h01);
    idle("side one");
    check(8'(head_side_one), 8'h01);
    check(8'(ready), 8'h00);
    check(8'(head_loaded), 8'h00);
    send(2'h1, cmd_side, 8'h00);
    idle("side zero");
    check(8'({head_side_one, ready, head_loaded}), 8'h03);
    activity = 1'b1;
    repeat (8) @(negedge clk);
    check(8'(activity_led), 8'h01);
    activity = 1'b0;
    repeat (8) @(negedge clk);
    check(8'(activity_led), 8'h00);
    $display("test activity done");
    // long writes outlast the two-cycle sends, so the queue fills and refuses
    for (int i = 0; i < 20; i++) send(2'h1, cmd_write, 8'hff);
    idle("fill");
    check(8'(refused), 8'h01);
    send(2'h2, cmd_step_in, 8'h05);
    idle("other unit");
    check(8'(track), 8'h3c);
    check(8'(selected), 8'h00);
    final_report();
  end
endmodule
`default_nettype wire

// *** verilog/cmd_fifo.sv ***
// parameterised synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // system
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;
  always_comb begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wr  = push ? ((int'(wr_ff) == DEPTH-1) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? ((int'(rd_ff) == DEPTH-1) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  assign in_ready  = int'(cnt_ff) != DEPTH;
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];
endmodule
`default_nettype wire

// *** verilog/fdd_cfg.svh ***
// constants for the flexible disk input-line link
// assumes a 10 MHz system clock shared by both ends
`ifndef FDD_CFG_SVH
`define FDD_CFG_SVH
`define CLK_HZ            10000000
`define DIR_SETUP_US      1
// scale by kHz first so the 590 us product stays inside a 32-bit int
`define DIR_SETUP_CYC     (((`CLK_HZ / 1000) * `DIR_SETUP_US + 999) / 1000)
`define ERASE_US          590
`define ERASE_CYC         (((`CLK_HZ / 1000) * `ERASE_US + 999) / 1000)
`define SIDE_SETTLE_US    100
`define SIDE_SETTLE_CYC   (((`CLK_HZ / 1000) * `SIDE_SETTLE_US + 999) / 1000)
`define STEP_LOW_CYC      10
`define STEP_HIGH_CYC     10
`define READY_INDEX_MIN   3
`define LOW_CUR_TRACK     44
`define FILTER_TRACK      60
`define LAST_TRACK        76
`define FIFO_DEPTH        16
`endif

// *** verilog/fdd_drive.sv ***
// drive end: input-line receivers and head/write/LED control
// assumes lines arrive asynchronously from the controller cable
// Function
// RULE_01: all lines true when driven low
// RULE_02: twelve inputs, two of them optional
// RULE_03: listen only when jumpered select is low
// RULE_04: system gives each drive unique address
// RULE_05: direction low steps inward, high outward
// RULE_06: one track per falling step edge
// RULE_07: direction stable one microsecond before step
// RULE_08: write current flips on write-data fall
// RULE_09: write gate enables writing, blocks stepping
// RULE_10: controller waits 590 us after writing
// RULE_11: side line low picks side one
// RULE_12: controller waits 100 us after side change
// RULE_13: controller asserts low current on tracks 44+
// RULE_14: inner line cuts write current twenty percent
// RULE_15: controller asserts filter on tracks 60+
// RULE_16: head engage plus ready loads head
// RULE_17: activity input lights the LED
// RULE_18: ready after three index pulses, side rule
// RULE_19: ignore chain activity while unselected; the activity LED still follows activity_n when unselected
`include "fdd_cfg.svh"
`default_nettype none
module fdd_drive
  import fdd_pkg::*;
#(
  parameter int TRACKS = `LAST_TRACK + 1
) (
  // system
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // strap and media sense
  input  wire logic [3:0] address_jumper,
  input  wire logic       index_pulse,
  input  wire logic       disk_present,
  input  wire logic       two_sided_media,
  // line side
  fdd_if.drive            lines,
  // mechanism side
  output logic            selected,
  output logic [6:0]      track,
  output logic            step_pulse,
  output logic            step_inward,
  output logic            write_enable,
  output logic            read_enable,
  output logic            write_polarity,
  output logic            write_current_low,
  output logic            read_filter,
  output logic            head_side_one,
  output logic            head_loaded,
  output logic            ready,
  output logic            activity_led
);
  // lines: sel4 dir step wd wg side inner engage activity, plus index
  localparam int NL = 13;
  // straps and media sense: jumpers, present, two-sided
  localparam int NP = 6;
  logic [NL-1:0] raw, s1_ff, s2_ff, prev_ff;
  logic [NP-1:0] pin_raw, p1_ff, p2_ff;
  logic [3:0]    strap;
  logic          present, two_sided;
  logic          sel, fall_step, fall_wd, rise_idx;
  logic [6:0]    track_ff, nxt_track;
  logic [1:0]    idx_cnt_ff, nxt_idx_cnt;
  logic          pol_ff, nxt_pol, stp_ff, nxt_stp, in_ff, nxt_in;
  logic          sel_ff, nxt_sel, we_ff, nxt_we, re_ff, nxt_re;
  logic          lowc_ff, nxt_lowc, filt_ff, nxt_filt, side_ff, nxt_side;
  logic          load_ff, nxt_load, rdy_ff, nxt_rdy, led_ff, nxt_led;

  // one jumper expected; several fitted respond to any of them
  function automatic logic unit_match(input logic [3:0] strap, input logic [3:0] sel_n);
    unit_match = |(strap & ~sel_n);
  endfunction

  assign raw = {index_pulse, lines.unit_sel_n, lines.direction_n, lines.step_n,
                lines.write_data_n, lines.write_gate_n, lines.side_sel_n,
                lines.inner_track_n, lines.head_engage_n, lines.activity_n}; // RULE_02

  assign pin_raw = {two_sided_media, disk_present, address_jumper};

  // two flops per line before anything looks at it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff   <= {1'b0, {(NL-1){1'b1}}};
      s2_ff   <= {1'b0, {(NL-1){1'b1}}};
      prev_ff <= {1'b0, {(NL-1){1'b1}}};
      p1_ff   <= '0;
      p2_ff   <= '0;
    end else begin
      s1_ff   <= raw;
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff;
      p1_ff   <= pin_raw;
      p2_ff   <= p1_ff;
    end
  end

  always_comb begin
    strap     = p2_ff[3:0];
    present   = p2_ff[4];
    two_sided = p2_ff[5];
    sel       = unit_match(strap, s2_ff[11:8]); // RULE_03
    fall_step = sel && prev_ff[6] && !s2_ff[6]; // RULE_06 RULE_19
    fall_wd   = sel && prev_ff[5] && !s2_ff[5]; // RULE_08 RULE_19
    rise_idx  = s2_ff[12] && !prev_ff[12];
    nxt_track = track_ff;
    nxt_stp   = 1'b0;
    nxt_in    = in_ff;
    if (fall_step && s2_ff[4]) begin // RULE_09
      nxt_stp = 1'b1;
      nxt_in  = !s2_ff[7]; // RULE_05
      if (!s2_ff[7] && int'(track_ff) < TRACKS - 1) nxt_track = track_ff + 1'b1;
      if (s2_ff[7] && track_ff != 7'h00) nxt_track = track_ff - 1'b1;
    end
    nxt_pol = fall_wd && !s2_ff[4] ? ~pol_ff : pol_ff;
    nxt_idx_cnt = idx_cnt_ff;
    if (!present) nxt_idx_cnt = 2'h0;
    else if (rise_idx && int'(idx_cnt_ff) < `READY_INDEX_MIN) nxt_idx_cnt = idx_cnt_ff + 1'b1;
    nxt_rdy  = present && int'(idx_cnt_ff) >= `READY_INDEX_MIN
               && (two_sided || !side_ff); // RULE_18
    nxt_sel  = sel;
    nxt_we   = sel && !s2_ff[4]; // RULE_09 RULE_01
    nxt_re   = sel && s2_ff[4]; // RULE_09
    nxt_lowc = sel && !s2_ff[4] && !s2_ff[2]; // RULE_14
    nxt_filt = sel && s2_ff[4] && !s2_ff[2];
    // side is held while another unit owns the chain
    nxt_side = sel ? !s2_ff[3] : side_ff; // RULE_11 RULE_19
    nxt_load = sel && !s2_ff[1] && rdy_ff; // RULE_16
    nxt_led  = !s2_ff[0]; // RULE_17
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      track_ff   <= '0;
      idx_cnt_ff <= '0;
      pol_ff     <= 1'b0;
      stp_ff     <= 1'b0;
      in_ff      <= 1'b0;
      rdy_ff     <= 1'b0;
      sel_ff     <= 1'b0;
      we_ff      <= 1'b0;
      re_ff      <= 1'b0;
      lowc_ff    <= 1'b0;
      filt_ff    <= 1'b0;
      side_ff    <= 1'b0;
      load_ff    <= 1'b0;
      led_ff     <= 1'b0;
    end else begin
      track_ff   <= nxt_track;
      idx_cnt_ff <= nxt_idx_cnt;
      pol_ff     <= nxt_pol;
      stp_ff     <= nxt_stp;
      in_ff      <= nxt_in;
      rdy_ff     <= nxt_rdy;
      sel_ff     <= nxt_sel;
      we_ff      <= nxt_we;
      re_ff      <= nxt_re;
      lowc_ff    <= nxt_lowc;
      filt_ff    <= nxt_filt;
      side_ff    <= nxt_side;
      load_ff    <= nxt_load;
      led_ff     <= nxt_led;
    end
  end

  assign selected          = sel_ff;
  assign track             = track_ff;
  assign step_pulse        = stp_ff;
  assign step_inward       = in_ff;
  assign write_enable      = we_ff;
  assign read_enable       = re_ff;
  assign write_polarity    = pol_ff;
  assign write_current_low = lowc_ff;
  assign read_filter       = filt_ff;
  assign head_side_one     = side_ff;
  assign head_loaded       = load_ff;
  assign ready             = rdy_ff;
  assign activity_led      = led_ff;
endmodule
`default_nettype wire

// *** verilog/fdd_host.sv ***
// controller end: queues user commands and drives the input lines
// assumes the drive end samples lines through two flip-flops
`include "fdd_cfg.svh"
`default_nettype none
module fdd_host
  import fdd_pkg::*;
#(
  parameter int ERASE_CYC = `ERASE_CYC
) (
  // system
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // user command port
  input  wire logic [1:0] unit,
  input  wire cmd_t       cmd,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       activity,
  output logic            busy,
  // line side
  fdd_if.host             lines
);
  typedef enum logic [2:0] {
    st_idle, st_dir, st_low, st_high, st_wr, st_settle
  } state_t;
  cmd_t        fifo_cmd;
  logic        fifo_valid, fifo_ready;
  state_t      st_ff, nxt_st;
  logic [12:0] cnt_ff, nxt_cnt;
  logic [7:0]  left_ff, nxt_left;
  logic [6:0]  track_ff, nxt_track;
  logic [3:0]  sel_ff, nxt_sel;
  logic        dir_ff, nxt_dir, step_ff, nxt_step, wd_ff, nxt_wd, wg_ff, nxt_wg;
  logic        side_ff, nxt_side, inner_ff, nxt_inner, load_ff, nxt_load;
  logic        act_ff, busy_ff, nxt_busy;

  cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .in_data  (cmd),
    .in_valid (cmd_valid),
    .in_ready (cmd_ready),
    .out_data (fifo_cmd),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  always_comb begin
    nxt_st = st_ff; nxt_cnt = cnt_ff; nxt_left = left_ff; nxt_track = track_ff;
    nxt_sel = sel_ff; nxt_dir = dir_ff; nxt_step = step_ff; nxt_wd = wd_ff;
    nxt_wg = wg_ff; nxt_side = side_ff; nxt_inner = inner_ff; nxt_load = load_ff;
    nxt_busy = busy_ff;
    fifo_ready = 1'b0;
    case (st_ff)
      st_idle: begin
        nxt_busy = 1'b0;
        if (fifo_valid) begin
          fifo_ready = 1'b1;
          nxt_busy   = 1'b1;
          nxt_sel    = ~(4'h1 << unit); // RULE_03
          case (fifo_cmd.kind)
            cmd_step_in, cmd_step_out: begin
              nxt_dir  = (fifo_cmd.kind == cmd_step_out); // RULE_05
              nxt_left = fifo_cmd.arg;
              nxt_cnt  = 13'(`DIR_SETUP_CYC); // RULE_07
              nxt_st   = (fifo_cmd.arg == 8'h00) ? st_idle : st_dir;
            end
            cmd_side: begin
              nxt_side = ~fifo_cmd.arg[0]; // RULE_11
              nxt_cnt  = 13'(`SIDE_SETTLE_CYC); // RULE_12
              nxt_st   = st_settle;
            end
            cmd_write: begin
              nxt_wg    = 1'b0;
              nxt_left  = fifo_cmd.arg;
              nxt_inner = !(int'(track_ff) >= `LOW_CUR_TRACK); // RULE_13
              nxt_st    = st_wr;
            end
            cmd_read: begin
              nxt_inner = !(int'(track_ff) >= `FILTER_TRACK); // RULE_15
            end
            cmd_load: begin
              nxt_load = ~fifo_cmd.arg[0];
            end
            default: ;
          endcase
        end
      end
      st_dir: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff <= 13'h0001) begin
          nxt_step = 1'b0; // RULE_06
          nxt_cnt  = 13'(`STEP_LOW_CYC);
          nxt_st   = st_low;
        end
      end
      st_low: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff <= 13'h0001) begin
          nxt_step = 1'b1;
          nxt_cnt  = 13'(`STEP_HIGH_CYC);
          if (!dir_ff && int'(track_ff) < `LAST_TRACK) nxt_track = track_ff + 1'b1;
          if (dir_ff && track_ff != 7'h00) nxt_track = track_ff - 1'b1;
          nxt_left = left_ff - 1'b1;
          nxt_st   = st_high;
        end
      end
      st_high: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff <= 13'h0001) begin
          nxt_cnt = 13'(`DIR_SETUP_CYC);
          nxt_st  = (left_ff == 8'h00) ? st_idle : st_dir;
        end
      end
      st_wr: begin
        // one flux reversal per two cycles, arg counts reversals
        nxt_wd = ~wd_ff; // RULE_08
        if (!wd_ff) begin
          nxt_left = left_ff - 1'b1;
          if (left_ff <= 8'h01) begin
            nxt_wd = 1'b1;
            nxt_wg = 1'b1;
            nxt_cnt = 13'(ERASE_CYC); // RULE_10
            nxt_st = st_settle;
          end
        end
      end
      st_settle: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff <= 13'h0001) nxt_st = st_idle;
      end
      default: nxt_st = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= st_idle; cnt_ff <= '0; left_ff <= '0; track_ff <= '0;
      sel_ff <= 4'hf; dir_ff <= 1'b1; step_ff <= 1'b1; wd_ff <= 1'b1;
      wg_ff <= 1'b1; side_ff <= 1'b1; inner_ff <= 1'b1; load_ff <= 1'b1;
      act_ff <= 1'b1; busy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; cnt_ff <= nxt_cnt; left_ff <= nxt_left; track_ff <= nxt_track;
      sel_ff <= nxt_sel; dir_ff <= nxt_dir; step_ff <= nxt_step; wd_ff <= nxt_wd;
      wg_ff <= nxt_wg; side_ff <= nxt_side; inner_ff <= nxt_inner; load_ff <= nxt_load;
      act_ff <= ~activity; busy_ff <= nxt_busy; // RULE_01
    end
  end

  assign lines.unit_sel_n    = sel_ff;
  assign lines.direction_n   = dir_ff;
  assign lines.step_n        = step_ff;
  assign lines.write_data_n  = wd_ff;
  assign lines.write_gate_n  = wg_ff;
  assign lines.side_sel_n    = side_ff;
  assign lines.inner_track_n = inner_ff;
  assign lines.head_engage_n = load_ff;
  assign lines.activity_n    = act_ff;
  assign busy                = busy_ff;
endmodule
`default_nettype wire

// *** verilog/fdd_if.sv ***
// the twelve active-low input lines from controller to drive
// assumes one controller drives all lines; the drive only listens
`default_nettype none
interface fdd_if;
  logic [3:0] unit_sel_n;
  logic       direction_n;
  logic       step_n;
  logic       write_data_n;
  logic       write_gate_n;
  logic       side_sel_n;
  logic       inner_track_n;
  logic       head_engage_n;
  logic       activity_n;
  modport host (
    output unit_sel_n, direction_n, step_n, write_data_n, write_gate_n,
    output side_sel_n, inner_track_n, head_engage_n, activity_n
  );
  modport drive (
    input unit_sel_n, direction_n, step_n, write_data_n, write_gate_n,
    input side_sel_n, inner_track_n, head_engage_n, activity_n
  );
endinterface
`default_nettype wire

// *** verilog/fdd_pkg.sv ***
// types shared by both ends of the disk input-line link
// assumes fdd_cfg.svh is compiled alongside
`default_nettype none
package fdd_pkg;
  typedef enum logic [2:0] {
    cmd_step_in,
    cmd_step_out,
    cmd_side,
    cmd_write,
    cmd_read,
    cmd_load
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t  kind;
    logic [7:0] arg;
  } cmd_t;
endpackage
`default_nettype wire
